// ==== rtl/ebt_timer.sv ====
// Three 8-bit compare timers with square-wave output and 16-bit cascade
//
// Operation
// RULE_01 - Match toggles wave output in square-wave mode
// RULE_02 - 8-bit match clears counter, counting continues
// RULE_03 - Match raises irq as counter clears
// RULE_04 - Run enable low forces wave output 0
// RULE_05 - Enabled wave output starts low
// RULE_06 - Software orders square-wave setup steps
// RULE_07 - Software stops timer before clock change
// RULE_08 - Timer 50 clock select decode
// RULE_09 - Timer 60 clock select decode
// RULE_10 - Timer 61 clock select decode
// RULE_11 - Cascade: timer 50 upper, 60 lower
// RULE_12 - Cascade: timer 60 enable alone controls
// RULE_13 - Cascade full match clears both bytes
// RULE_14 - Cascade match raises only timer 60 irq
// RULE_15 - Software orders 16-bit interval setup
// RULE_16 - External clock counts valid input edges
// RULE_17 - Lower byte wrap carries into upper
`timescale 1ns/10ps
`include "ebt_regs.svh"
module ebt_timer (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire ebt_pkg::ebt_cfg_t i_cfg_t50,
  input wire ebt_pkg::ebt_cfg_t i_cfg_t60,
  input wire ebt_pkg::ebt_cfg_t i_cfg_t61,
  input wire logic i_cascade_16b,
  input wire logic i_subsystem_clock,
  input wire logic i_ext_count_t60,
  input wire logic i_ext_count_t61,
  output logic [2:0] o_wave_output_pin,
  output logic [2:0] o_match_irq,
  output logic [`EBT_CNT_W-1:0] o_count_t50,
  output logic [`EBT_CNT_W-1:0] o_count_t60,
  output logic [`EBT_CNT_W-1:0] o_count_t61,
  output logic [2*`EBT_CNT_W-1:0] o_count_16b
);
  ebt_pkg::ebt_cfg_t cfg [3];
  logic [`EBT_CNT_W-1:0] cnt_q [3];
  logic [`EBT_CNT_W-1:0] cnt_d [3];
  logic [`EBT_EDIV_W-1:0] ediv_q [3];
  logic [`EBT_EDIV_W-1:0] ediv_d [3];
  logic [2:0] wave_q;
  logic [2:0] wave_d;
  logic [2:0] irq_q;
  logic [2:0] irq_d;
  logic [2:0] tick;
  logic [2:0] run;
  logic [`EBT_PRESC_W-1:0] presc_q;
  logic [`EBT_PRESC_W-1:0] presc_d;
  logic [2:0] in_prev_q;
  logic [2:0] in_prev_d;
  logic [2:0] edge_in;
  logic match16;

  assign cfg[0] = i_cfg_t50;
  assign cfg[1] = i_cfg_t60;
  assign cfg[2] = i_cfg_t61;

  always_comb begin
    presc_d = presc_q + `EBT_PRESC_W'(1);
    in_prev_d = {i_ext_count_t61, i_ext_count_t60, i_subsystem_clock};
    // Rising edge is the valid edge; inputs are already synchronous
    edge_in = in_prev_d & ~in_prev_q; // RULE_16
    match16 = (cnt_q[0] == cfg[0].compare_value_8b) &&
      (cnt_q[1] == cfg[1].compare_value_8b);
    tick = 3'h0;
    run = 3'h0;
    // Descending order: timer 50 may be clocked by timer 60 results
    for (int i = 2; i >= 0; i--) begin
      logic hit;
      logic clr;
      logic casc_pair;
      hit = 1'b0;
      clr = 1'b0;
      casc_pair = i_cascade_16b && (i != 2);
      run[i] = (casc_pair && i == 0) ? cfg[1].count_run_enable : cfg[i].count_run_enable; // RULE_12
      ediv_d[i] = ediv_q[i];
      if (i != 0) begin
        if (!run[i]) begin
          ediv_d[i] = '0;
        end else if (edge_in[i]) begin
          ediv_d[i] = ediv_q[i] + `EBT_EDIV_W'(1);
        end
        case (cfg[i].clk_sel)
          `EBT_SEL6X_MAIN: tick[i] = 1'b1; // RULE_09 RULE_10
          `EBT_SEL6X_DIVM: begin
            if (i == 1) begin
              tick[i] = (presc_q & `EBT_MASK_DIV4) == `EBT_MASK_DIV4; // RULE_09
            end else begin
              tick[i] = (presc_q & `EBT_MASK_DIV16) == `EBT_MASK_DIV16; // RULE_10
            end
          end
          `EBT_SEL6X_EXT: tick[i] = edge_in[i]; // RULE_16
          `EBT_SEL6X_EXT_DIV2: tick[i] = edge_in[i] && (ediv_q[i][0] == 1'b1);
          `EBT_SEL6X_EXT_DIV4: tick[i] = edge_in[i] && (ediv_q[i][1:0] == 2'h3);
          `EBT_SEL6X_EXT_DIV8: tick[i] = edge_in[i] && (ediv_q[i] == 3'h7);
          default: tick[i] = 1'b0;
        endcase
      end else if (i_cascade_16b) begin
        // Upper byte advances only on a lower-byte wrap
        tick[0] = tick[1] && (cnt_q[1] == `EBT_CNT_TOP) && !match16; // RULE_17
        clr = tick[1] && match16; // RULE_13
      end else begin
        case (cfg[0].clk_sel)
          `EBT_SEL50_MAIN: tick[0] = 1'b1; // RULE_08
          `EBT_SEL50_DIV8: tick[0] = (presc_q & `EBT_MASK_DIV8) == `EBT_MASK_DIV8;
          `EBT_SEL50_DIV128: tick[0] = (presc_q & `EBT_MASK_DIV128) == `EBT_MASK_DIV128;
          `EBT_SEL50_SUB: tick[0] = edge_in[0];
          `EBT_SEL50_T60_MATCH: tick[0] = irq_d[1];
          `EBT_SEL50_T60_OUT: tick[0] = wave_d[1] && !wave_q[1];
          default: tick[0] = 1'b0;
        endcase
      end
      hit = casc_pair ? match16 : (cnt_q[i] == cfg[i].compare_value_8b);
      cnt_d[i] = cnt_q[i];
      wave_d[i] = wave_q[i];
      irq_d[i] = 1'b0;
      if (!run[i]) begin
        cnt_d[i] = `EBT_CNT_RST;
        wave_d[i] = 1'b0; // RULE_04
      end else if (clr) begin
        cnt_d[i] = `EBT_CNT_RST; // RULE_13
      end else if (tick[i]) begin
        if (hit) begin
          cnt_d[i] = `EBT_CNT_RST; // RULE_02 RULE_13
          irq_d[i] = !(casc_pair && i == 0); // RULE_03 RULE_14
          wave_d[i] = ~wave_q[i]; // RULE_01
        end else begin
          cnt_d[i] = cnt_q[i] + `EBT_CNT_W'(1);
        end
      end
      // Disabled pin holds low so the first toggle after enable rises
      if (!cfg[i].pin_out_en || (casc_pair && i == 0)) begin
        wave_d[i] = 1'b0; // RULE_05
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      presc_q <= '0;
      in_prev_q <= 3'h0;
      wave_q <= 3'h0;
      irq_q <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= `EBT_CNT_RST;
        ediv_q[i] <= '0;
      end
    end else begin
      presc_q <= presc_d;
      in_prev_q <= in_prev_d;
      wave_q <= wave_d;
      irq_q <= irq_d;
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= cnt_d[i];
        ediv_q[i] <= ediv_d[i];
      end
    end
  end

  assign o_wave_output_pin = wave_q;
  assign o_match_irq = irq_q;
  assign o_count_t50 = cnt_q[0];
  assign o_count_t60 = cnt_q[1];
  assign o_count_t61 = cnt_q[2];
  assign o_count_16b = {cnt_q[0], cnt_q[1]}; // RULE_11

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  property p_toggle;
    run[2] && cfg[2].pin_out_en && tick[2] && cnt_q[2] == cfg[2].compare_value_8b
      |=> o_wave_output_pin[2] != $past(o_wave_output_pin[2]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("wave did not toggle on match"); // RULE_01

  property p_clear;
    run[2] && tick[2] && cnt_q[2] == cfg[2].compare_value_8b |=> o_count_t61 == 8'h00 ##1
      (o_count_t61 == 8'h00 || o_count_t61 == 8'h01);
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared on match"); // RULE_02

  property p_irq;
    !i_cascade_16b && run[0] && tick[0] && cnt_q[0] == cfg[0].compare_value_8b
      |=> o_match_irq[0] && o_count_t50 == 8'h00;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not with clear"); // RULE_03

  property p_stop;
    !cfg[1].count_run_enable |=> !o_wave_output_pin[1] && o_count_t60 == 8'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer drives wave"); // RULE_04

  property p_start_low;
    $rose(cfg[2].pin_out_en) |-> !o_wave_output_pin[2];
  endproperty
  a_start_low: assert property (p_start_low) else $error("wave not low at enable"); // RULE_05

  property p_sel50;
    !i_cascade_16b && run[0] && cfg[0].clk_sel == 3'h0 && $stable(cfg[0]) &&
      cnt_q[0] != cfg[0].compare_value_8b |=> o_count_t50 == $past(o_count_t50) + 8'h01;
  endproperty
  a_sel50: assert property (p_sel50) else $error("main clock select wrong"); // RULE_08

  property p_sel60;
    cfg[1].clk_sel == 3'h1 && tick[1] |-> presc_q[1:0] == 2'h3;
  endproperty
  a_sel60: assert property (p_sel60) else $error("timer 60 divide wrong"); // RULE_09

  property p_sel61;
    cfg[2].clk_sel == 3'h1 && tick[2] |-> presc_q[3:0] == 4'hF;
  endproperty
  a_sel61: assert property (p_sel61) else $error("timer 61 divide wrong"); // RULE_10

  // Judged from the pin itself, not from the internal edge term
  property p_ext;
    cfg[2].clk_sel == 3'h2 && run[2] && $rose(i_ext_count_t61) &&
      cnt_q[2] != cfg[2].compare_value_8b |=> o_count_t61 == $past(o_count_t61) + 8'h01;
  endproperty
  a_ext: assert property (p_ext) else $error("external edge not counted"); // RULE_16

  property p_casc_run;
    i_cascade_16b && !cfg[1].count_run_enable |=> o_count_16b == 16'h0000;
  endproperty
  a_casc_run: assert property (p_casc_run) else $error("cascade not held by timer 60"); // RULE_12

  property p_casc_match;
    i_cascade_16b && run[1] && tick[1] && match16
      |=> o_count_16b == 16'h0000 && o_match_irq[1:0] == 2'h2;
  endproperty
  a_casc_match: assert property (p_casc_match) else $error("cascade match wrong"); // RULE_13

  property p_no_irq50;
    i_cascade_16b && $past(i_cascade_16b) |-> !o_match_irq[0];
  endproperty
  a_no_irq50: assert property (p_no_irq50) else $error("timer 50 irq in cascade"); // RULE_14

  property p_carry;
    i_cascade_16b && run[1] && tick[1] && cnt_q[1] == 8'hFF && !match16
      |=> o_count_t60 == 8'h00 && o_count_t50 == $past(o_count_t50) + 8'h01;
  endproperty
  a_carry: assert property (p_carry) else $error("carry into upper byte lost"); // RULE_17

  c_wave: cover property (run[1] && cfg[1].pin_out_en ##1 $rose(o_wave_output_pin[1]));
  c_casc: cover property (i_cascade_16b && o_match_irq[1]);
  c_chain: cover property (cfg[0].clk_sel == 3'h4 && tick[0]);
  c_ext8: cover property (cfg[1].clk_sel == 3'h5 && tick[1]);
endmodule // ebt_timer

// ==== rtl/ebt_regs.svh ====
// Constants for the three-channel 8-bit compare timer block
`ifndef EBT_REGS_SVH
`define EBT_REGS_SVH
`define EBT_CNT_W 8
`define EBT_CNT_RST 8'h00
`define EBT_CNT_TOP 8'hFF
`define EBT_SEL_W 3
`define EBT_PRESC_W 7
`define EBT_EDIV_W 3
// Timer 50 clock select codes
`define EBT_SEL50_MAIN 3'h0
`define EBT_SEL50_DIV8 3'h1
`define EBT_SEL50_DIV128 3'h2
`define EBT_SEL50_SUB 3'h3
`define EBT_SEL50_T60_MATCH 3'h4
`define EBT_SEL50_T60_OUT 3'h5
// Timer 60 and 61 clock select codes
`define EBT_SEL6X_MAIN 3'h0
`define EBT_SEL6X_DIVM 3'h1
`define EBT_SEL6X_EXT 3'h2
`define EBT_SEL6X_EXT_DIV2 3'h3
`define EBT_SEL6X_EXT_DIV4 3'h4
`define EBT_SEL6X_EXT_DIV8 3'h5
// Prescaler masks: tick when masked low bits are all ones
`define EBT_MASK_DIV4 7'h03
`define EBT_MASK_DIV8 7'h07
`define EBT_MASK_DIV16 7'h0F
`define EBT_MASK_DIV128 7'h7F
`endif

// ==== rtl/ebt_pkg.sv ====
// Types for the three-channel 8-bit compare timer block
`include "ebt_regs.svh"
package ebt_pkg;
  typedef struct packed {
    logic count_run_enable;
    logic pin_out_en;
    logic [`EBT_SEL_W-1:0] clk_sel;
    logic [`EBT_CNT_W-1:0] compare_value_8b;
  } ebt_cfg_t;
endpackage

// ==== verification/ebt_ext_drv.sv ====
// Far-side model: subsystem clock and external count inputs
`timescale 1ns/10ps
module ebt_ext_drv (
  input wire logic i_sys_clk,
  output logic o_sub_clk,
  output logic o_ext_t60,
  output logic o_ext_t61
);
  int seed = 32'he7c3;
  logic [31:0] r;
  // Each level lasts a cycle at least, so every rising edge is seen
  initial begin
    o_sub_clk = 1'h0;
    o_ext_t60 = 1'h0;
    o_ext_t61 = 1'h0;
    forever begin
      @(posedge i_sys_clk);
      #1;
      r = $random(seed);
      if (r[1:0] == 2'h0) o_sub_clk = !o_sub_clk;
      if (r[3:2] == 2'h0) o_ext_t60 = !o_ext_t60;
      if (r[5:4] == 2'h0) o_ext_t61 = !o_ext_t61;
    end
  end
endmodule // ebt_ext_drv

// ==== verification/test_eight_bit_timer_square_wave_cascade.sv ====
// Self-checking bench for the three-channel compare timer
`timescale 1ns/10ps
module test_eight_bit_timer_square_wave_cascade;
  logic i_sys_clk = 1'h0;
  logic i_rst = 1'h1;
  logic casc = 1'h0;
  logic sub, ext60, ext61;
  ebt_pkg::ebt_cfg_t cfg [3] = '{default: '0};
  logic [2:0] o_wave_output_pin, o_match_irq;
  logic [7:0] o_count_t50, o_count_t60, o_count_t61;
  logic [15:0] o_count_16b;
  int seed, n_fail, check_count, pr, m, i;
  int cnt [3];
  int dv [3];
  bit [2:0] wv, iq, pv;
  always #4 i_sys_clk = !i_sys_clk;
  ebt_timer ebt_timer_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cfg_t50(cfg[0]),
    .i_cfg_t60(cfg[1]), .i_cfg_t61(cfg[2]), .i_cascade_16b(casc), .i_subsystem_clock(sub),
    .i_ext_count_t60(ext60), .i_ext_count_t61(ext61), .o_wave_output_pin(o_wave_output_pin),
    .o_match_irq(o_match_irq), .o_count_t50(o_count_t50), .o_count_t60(o_count_t60),
    .o_count_t61(o_count_t61), .o_count_16b(o_count_16b));
  ebt_ext_drv ebt_ext_drv_inst (.i_sys_clk(i_sys_clk), .o_sub_clk(sub), .o_ext_t60(ext60),
    .o_ext_t61(ext61));
  task automatic upd(int k, bit run, bit pin, bit tk, bit mt);
    iq[k] = 1'b0;
    if (!run) begin
      cnt[k] = 0;
      wv[k] = 1'b0;
    end else if (tk && mt) begin
      cnt[k] = 0;
      iq[k] = 1'b1;
      wv[k] = wv[k] ^ pin;
    end else if (tk) cnt[k] = (cnt[k] + 1) & 255;
    if (!pin) wv[k] = 1'b0;
  endtask
  always @(posedge i_sys_clk or posedge i_rst) begin : mdl
    int k, n;
    bit [2:0] ev, tk;
    bit m60, w60, mt, cy;
    if (i_rst) begin
      pr = 0;
      wv = 0;
      iq = 0;
      pv = 0;
      for (k = 0; k < 3; k++) begin
        cnt[k] = 0;
        dv[k] = 0;
      end
    end else begin
      ev = {ext61, ext60, sub} & ~pv;
      pv = {ext61, ext60, sub};
      tk = 0;
      for (k = 1; k < 3; k++) begin
        n = cfg[k].clk_sel;
        m = (k == 1) ? 3 : 15;
        if (n == 0) tk[k] = 1'b1;
        else if (n == 1) tk[k] = (pr & m) == m;
        else if (n < 6 && ev[k] && cfg[k].count_run_enable) begin
          dv[k]++;
          if (dv[k] == (1 << (n - 2))) begin
            tk[k] = 1'b1;
            dv[k] = 0;
          end
        end
        if (!cfg[k].count_run_enable) dv[k] = 0;
      end
      m60 = cfg[1].count_run_enable && tk[1] && cnt[1] == cfg[1].compare_value_8b;
      w60 = m60 && cfg[1].pin_out_en && !wv[1];
      case (cfg[0].clk_sel)
        0: tk[0] = 1'b1;
        1: tk[0] = (pr & 7) == 7;
        2: tk[0] = (pr & 127) == 127;
        3: tk[0] = ev[0];
        4: tk[0] = m60;
        5: tk[0] = w60;
        default: tk[0] = 1'b0;
      endcase
      pr = (pr + 1) & 127;
      upd(2, cfg[2].count_run_enable, cfg[2].pin_out_en, tk[2], cnt[2] == cfg[2].compare_value_8b);
      if (casc) begin
        mt = cnt[0] == cfg[0].compare_value_8b && cnt[1] == cfg[1].compare_value_8b;
        cy = tk[1] && !mt && cnt[1] == 255;
        upd(1, cfg[1].count_run_enable, cfg[1].pin_out_en, tk[1], mt);
        if (!cfg[1].count_run_enable || (tk[1] && mt)) cnt[0] = 0;
        else if (cy) cnt[0] = cnt[0] + 1;
        wv[0] = 1'b0;
        iq[0] = 1'b0;
      end else begin
        for (k = 0; k < 2; k++) begin
          upd(k, cfg[k].count_run_enable, cfg[k].pin_out_en, tk[k],
            cnt[k] == cfg[k].compare_value_8b);
        end
      end
    end
  end
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_wave(logic [2:0] got, bit [2:0] exp);
    chk(16'(got), 16'(exp));
  endtask
  task automatic chk_irq(logic [2:0] got, bit [2:0] exp);
    chk(16'(got), 16'(exp));
  endtask
  task automatic chk_cnt(logic [15:0] got, int exp);
    chk(got, 16'(exp));
  endtask
  always @(negedge i_sys_clk) begin
    chk_wave(o_wave_output_pin, wv);
    chk_irq(o_match_irq, iq);
    chk_cnt(16'(o_count_t50), cnt[0] & 255);
    chk_cnt(16'(o_count_t60), cnt[1] & 255);
    chk_cnt(16'(o_count_t61), cnt[2] & 255);
    chk_cnt(o_count_16b, ((cnt[0] & 255) << 8) | (cnt[1] & 255));
  end
  task automatic wt(int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // Stop, mode, clock, pin, compare, then start
  task automatic cfgset(bit [2:0] sel, bit pin, bit [7:0] msk, bit [7:0] mu, bit cs);
    int k;
    for (k = 0; k < 3; k++) cfg[k].count_run_enable = 1'b0;
    casc = cs;
    wt(1);
    for (k = 0; k < 3; k++) cfg[k].clk_sel = sel;
    wt(1);
    // Upper byte pin stays off in cascade
    for (k = 0; k < 3; k++) cfg[k].pin_out_en = pin && !(cs && k == 0);
    wt(1);
    for (k = 0; k < 3; k++) cfg[k].compare_value_8b = 8'($random(seed)) & (k ? msk : mu);
    wt(1);
    for (k = 0; k < 3; k++) cfg[k].count_run_enable = 1'b1;
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    seed = 32'he7c3;
    wt(5);
    i_rst = 1'h0;
    wt(2);
    for (i = 0; i < 16; i++) begin
      cfgset(i[2:0], i[3], 8'h07, 8'h07, 1'b0);
      wt(150);
      cfg[i % 3].count_run_enable = 1'b0;
      wt(3);
      cfg[i % 3].count_run_enable = 1'b1;
      wt(150);
    end
    for (i = 0; i < 4; i++) begin
      cfgset(i[0] ? 3'h2 : 3'h0, i[1], 8'hFF, 8'h01, 1'b1);
      wt(600);
      cfg[0].count_run_enable = 1'b0;
      wt(600);
    end
    conclude();
  end
  // Scenarios need about 10000 cycles
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    n_fail++;
    conclude();
  end
endmodule // test_eight_bit_timer_square_wave_cascade
